/* core/adc_cmd_defines.svh */
`ifndef ADC_CMD_DEFINES_SVH
`define ADC_CMD_DEFINES_SVH

// ----------------------------------------
// widths and depths
// ----------------------------------------
`define CMD_W              8
`define RESULT_W           24
`define REG_ADDR_W         4
`define CMD_FIFO_DEPTH     16
`define HOLD_CNT_W         18

// ----------------------------------------
// timing
// ----------------------------------------
`define SYS_CLK_MHZ        250
`define RESET_HOLD_TIME_US 600
`define RESET_HOLD_CYCLES  (`RESET_HOLD_TIME_US * `SYS_CLK_MHZ)
`define POWERUP_CYCLES     65536

// ----------------------------------------
// command encodings, don't-care bit 0 reads as zero
// ----------------------------------------
`define CMD_RESUME         8'h00
`define CMD_SLEEP          8'h02
`define CMD_SYNC           8'h04
`define CMD_RESET          8'h06
`define CMD_NO_OPERATION   8'hFF
`define CMD_READ_ONCE      8'h12
`define CMD_AUTO_LOAD      8'h14
`define CMD_STOP_AUTO      8'h16
`define CMD_REG_READ_HI    4'h2
`define CMD_REG_WRITE_HI   4'h4
`define CMD_COUNT_HI       4'h0
`define CMD_SYS_OFFSET_CAL 8'h60
`define CMD_SYS_GAIN_CAL   8'h61
`define CMD_INT_OFFSET_CAL 8'h62

// ----------------------------------------
// coefficient register bases, low byte first
// ----------------------------------------
`define OFFSET_COEF_BASE   4'h4
`define GAIN_COEF_BASE     4'h7
`define COEF_LAST_INDEX    4'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define AUTO_LOAD_RESET    1'b1
`define CONV_ENABLE_RESET  1'b1

`endif

/* core/adc_cmd_pkg.sv */
package adc_cmd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_COUNT,
    ST_READOUT,
    ST_WR_COUNT,
    ST_WR_DATA,
    ST_CAL_WAIT,
    ST_CAL_WRITE,
    ST_HOLD
  } decode_state_type;

  typedef enum logic [1:0] {
    CAL_SYS_OFFSET,
    CAL_SYS_GAIN,
    CAL_INT_OFFSET
  } cal_kind_type;

endpackage

/* core/stream_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

`default_nettype wire

/* core/cmd_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module cmd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)(
  input  wire logic sys_clk,
  input  wire logic rst,
  stream_if.sink    inPort,
  stream_if.source  outPort
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gDepthCheck
    $error("cmd_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] outData_reg;
  logic             outValid_reg;

  wire              push = inPort.valid & inPort.ready;
  wire              pop  = outValid_reg & outPort.ready;
  wire              fill = (count_reg != (AW+1)'(outValid_reg)) & (~outValid_reg | outPort.ready);
  wire [AW:0]       depthCount = (AW+1)'(DEPTH);

  // the output register counts as a slot, so full is honest
  assign inPort.ready  = (count_reg != depthCount);
  assign outPort.valid = outValid_reg;
  assign outPort.data  = outData_reg;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inPort.data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_reg + AW'(push);
      rdPtr_reg <= rdPtr_reg + AW'(fill);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outData_reg  <= '0;
      outValid_reg <= 1'b0;
    end else if (fill) begin
      outData_reg  <= mem[rdPtr_reg];
      outValid_reg <= 1'b1;
    end else if (outPort.ready) begin
      outValid_reg <= 1'b0;
    end
  end
endmodule

`default_nettype wire

/* core/adc_serial_command_decoder.sv */
// Notes on behaviour
// - resume byte wakes at eighth clock rise
// - sleep byte stops after current conversion
// - sleep leaves voltage reference untouched
// - sleep/resume act like start pin
// - synchronise clears filter, restarts conversion
// - reset byte restores registers, clears filter
// - reset byte keeps serial interface state
// - reset holds device for 0.6 ms
// - auto load puts each result out
// - auto load change applies next ready
// - stop auto load applies next ready
// - read once loads latest result
// - read once accepted during last byte
// - register read returns count plus one
// - input ignored during register readout
// - register write stores count plus one
// - system offset calibration updates offset
// - system gain calibration updates gain
// - internal offset calibration updates offset
// - power-up hold blocks commands
// - auto load mode after any reset
// - output pin may also show ready
`timescale 1ns/1ps
`default_nettype none

`include "adc_cmd_defines.svh"

module adc_serial_command_decoder #(
  parameter int unsigned RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES,
  parameter int unsigned POWERUP_CYCLES    = `POWERUP_CYCLES,
  parameter int unsigned FIFO_DEPTH        = `CMD_FIFO_DEPTH
)(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    sclkPin,
  input  wire logic                    csNPin,
  input  wire logic                    dinPin,
  output logic                         doutPin,
  output logic                         doutOe,
  output logic                         resultReadyN,
  input  wire logic                    convDone,
  input  wire logic [`RESULT_W-1:0]    convResult,
  output logic                         convEnable,
  output logic                         filterClear,
  output logic                         regReset,
  output logic                         resetHold,
  input  wire logic                    readyOnOutputSelect,
  output logic [`REG_ADDR_W-1:0]       regRdAddr,
  input  wire logic [`CMD_W-1:0]       regRdData,
  output logic                         regWrEn,
  output logic [`REG_ADDR_W-1:0]       regWrAddr,
  output logic [`CMD_W-1:0]            regWrData,
  output logic                         calStart,
  output adc_cmd_pkg::cal_kind_type    calKind,
  input  wire logic                    calDone,
  input  wire logic [`RESULT_W-1:0]    calResult,
  output logic                         cmdFifoReady
);
  import adc_cmd_pkg::*;

  if (RESET_HOLD_CYCLES < 2 || RESET_HOLD_CYCLES >= (1 << `HOLD_CNT_W) ||
      POWERUP_CYCLES < 2 || POWERUP_CYCLES >= (1 << `HOLD_CNT_W)) begin : gHoldCheck
    $error("hold counts must lie between 2 and the counter range");
  end

  function automatic logic isCmd(input logic [`CMD_W-1:0] b, input logic [`CMD_W-1:0] code);
    isCmd = (b[`CMD_W-1:1] == code[`CMD_W-1:1]);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sclkSync_reg;
  logic [1:0] csNSync_reg;
  logic [1:0] dinSync_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclkSync_reg <= 3'h0;
      csNSync_reg  <= 2'h3;
      dinSync_reg  <= 2'h0;
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], sclkPin};
      csNSync_reg  <= {csNSync_reg[0], csNPin};
      dinSync_reg  <= {dinSync_reg[0], dinPin};
    end
  end

  wire csN      = csNSync_reg[1];
  wire sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2] & ~csN;
  wire sclkFall = ~sclkSync_reg[1] & sclkSync_reg[2] & ~csN;

  // ----------------------------------------
  // serial receive
  // ----------------------------------------
  logic [2:0]        bitCnt_reg;
  logic [`CMD_W-1:0] rxShift_reg;
  logic [`CMD_W-1:0] rxByte_reg;
  logic              byteDone_reg;

  decode_state_type  state_reg;
  decode_state_type  state_next;

  wire holdActive    = (state_reg == ST_HOLD);
  wire readoutActive = (state_reg == ST_READOUT);
  // resume is known once seven zero bits are in, bit 0 is don't-care
  // only an idle decoder wakes, so count and data bytes never do
  wire wakeHit       = sclkRise & (bitCnt_reg == 3'h7) & (rxShift_reg[6:0] == 7'h00)
                       & (state_reg == ST_IDLE);

  // only chip select realigns the bit count; reset byte leaves it alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bitCnt_reg   <= 3'h0;
      rxShift_reg  <= 8'h00;
      rxByte_reg   <= 8'h00;
      byteDone_reg <= 1'b0;
    end else begin
      byteDone_reg <= 1'b0;
      if (csN) begin
        bitCnt_reg <= 3'h0;
      end else if (sclkFall) begin
        rxShift_reg <= {rxShift_reg[6:0], dinSync_reg[1]};
        bitCnt_reg  <= bitCnt_reg + 3'h1;
        if (bitCnt_reg == 3'h7) begin
          rxByte_reg   <= {rxShift_reg[6:0], dinSync_reg[1]};
          byteDone_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // command queue
  // ----------------------------------------
  stream_if #(.WIDTH(`CMD_W)) wrSide ();
  stream_if #(.WIDTH(`CMD_W)) rdSide ();

  // bytes during readout or hold never reach the decoder
  assign wrSide.valid = byteDone_reg & ~readoutActive & ~holdActive;
  assign wrSide.data  = rxByte_reg;
  assign cmdFifoReady = wrSide.ready;

  cmd_fifo #(
    .WIDTH (`CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) uCmdFifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .inPort  (wrSide),
    .outPort (rdSide)
  );

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire [`CMD_W-1:0] cmdByte = rdSide.data;
  wire inIdle  = (state_reg == ST_IDLE);
  assign rdSide.ready = inIdle | (state_reg == ST_RD_COUNT) | (state_reg == ST_WR_COUNT)
                        | (state_reg == ST_WR_DATA);
  wire take    = rdSide.valid & rdSide.ready;
  wire cmdTake = take & inIdle;

  wire cmdResume    = cmdTake & isCmd(cmdByte, `CMD_RESUME);
  wire cmdSleep     = cmdTake & isCmd(cmdByte, `CMD_SLEEP);
  wire cmdSync      = cmdTake & isCmd(cmdByte, `CMD_SYNC);
  wire cmdReset     = cmdTake & isCmd(cmdByte, `CMD_RESET);
  wire cmdReadOnce  = cmdTake & isCmd(cmdByte, `CMD_READ_ONCE);
  wire cmdAutoLoad  = cmdTake & isCmd(cmdByte, `CMD_AUTO_LOAD);
  wire cmdStopAuto  = cmdTake & isCmd(cmdByte, `CMD_STOP_AUTO);
  wire cmdRegRead   = cmdTake & (cmdByte[7:4] == `CMD_REG_READ_HI);
  wire cmdRegWrite  = cmdTake & (cmdByte[7:4] == `CMD_REG_WRITE_HI);
  wire cmdSysOffset = cmdTake & (cmdByte == `CMD_SYS_OFFSET_CAL);
  wire cmdSysGain   = cmdTake & (cmdByte == `CMD_SYS_GAIN_CAL);
  wire cmdIntOffset = cmdTake & (cmdByte == `CMD_INT_OFFSET_CAL);
  wire cmdCal       = cmdSysOffset | cmdSysGain | cmdIntOffset;
  wire countOk      = (cmdByte[7:4] == `CMD_COUNT_HI);

  logic [`REG_ADDR_W-1:0] readAddr_reg, readAddr_next;
  logic [`REG_ADDR_W-1:0] readLeft_reg, readLeft_next;
  logic [`REG_ADDR_W-1:0] wrAddr_reg, wrAddr_next;
  logic [`REG_ADDR_W-1:0] wrLeft_reg, wrLeft_next;
  logic [`HOLD_CNT_W-1:0] holdCnt_reg, holdCnt_next;
  logic [`RESULT_W-1:0]   calCoef_reg;
  logic                   loadRegReq;
  logic                   loadRegPend_reg;
  logic                   wrPulse;

  wire [`CMD_W-1:0] calByte = (wrLeft_reg == `COEF_LAST_INDEX) ? calCoef_reg[7:0] :
                              (wrLeft_reg == 4'h1) ? calCoef_reg[15:8] : calCoef_reg[23:16];
  wire [`CMD_W-1:0] wrByte  = (state_reg == ST_WR_DATA) ? cmdByte : calByte;
  wire [`REG_ADDR_W-1:0] coefBase = (calKind == CAL_SYS_GAIN) ? `GAIN_COEF_BASE : `OFFSET_COEF_BASE;

  always_comb begin
    state_next    = state_reg;
    readAddr_next = readAddr_reg;
    readLeft_next = readLeft_reg;
    wrAddr_next   = wrAddr_reg;
    wrLeft_next   = wrLeft_reg;
    holdCnt_next  = holdCnt_reg;
    loadRegReq    = 1'b0;
    wrPulse       = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // anything not matched below falls through untouched
        if (cmdRegRead) begin
          state_next    = ST_RD_COUNT;
          readAddr_next = cmdByte[3:0];
        end else if (cmdRegWrite) begin
          state_next  = ST_WR_COUNT;
          wrAddr_next = cmdByte[3:0];
        end else if (cmdCal) begin
          state_next = ST_CAL_WAIT;
        end else if (cmdReset) begin
          state_next   = ST_HOLD;
          holdCnt_next = `HOLD_CNT_W'(RESET_HOLD_CYCLES);
        end
      end
      ST_RD_COUNT: begin
        if (take) begin
          state_next    = countOk ? ST_READOUT : ST_IDLE;
          readLeft_next = cmdByte[3:0];
          loadRegReq    = countOk;
        end
      end
      ST_READOUT: begin
        if (byteDone_reg) begin
          if (readLeft_reg == 4'h0) begin
            state_next = ST_IDLE;
          end else begin
            readAddr_next = readAddr_reg + 4'h1;
            readLeft_next = readLeft_reg - 4'h1;
            loadRegReq    = 1'b1;
          end
        end
      end
      ST_WR_COUNT: begin
        if (take) begin
          state_next  = countOk ? ST_WR_DATA : ST_IDLE;
          wrLeft_next = cmdByte[3:0];
        end
      end
      ST_WR_DATA: begin
        if (take) begin
          wrPulse     = 1'b1;
          wrAddr_next = wrAddr_reg + 4'h1;
          wrLeft_next = wrLeft_reg - 4'h1;
          if (wrLeft_reg == 4'h0) begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_CAL_WAIT: begin
        if (calDone) begin
          state_next  = ST_CAL_WRITE;
          wrAddr_next = coefBase;
          wrLeft_next = `COEF_LAST_INDEX;
        end
      end
      ST_CAL_WRITE: begin
        wrPulse     = 1'b1;
        wrAddr_next = wrAddr_reg + 4'h1;
        wrLeft_next = wrLeft_reg - 4'h1;
        if (wrLeft_reg == 4'h0) begin
          state_next = ST_IDLE;
        end
      end
      ST_HOLD: begin
        holdCnt_next = holdCnt_reg - `HOLD_CNT_W'(1);
        if (holdCnt_reg == `HOLD_CNT_W'(1)) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_HOLD;
      holdCnt_reg  <= `HOLD_CNT_W'(POWERUP_CYCLES);
      readAddr_reg <= 4'h0;
      readLeft_reg <= 4'h0;
      wrAddr_reg   <= 4'h0;
      wrLeft_reg   <= 4'h0;
    end else begin
      state_reg    <= state_next;
      holdCnt_reg  <= holdCnt_next;
      readAddr_reg <= readAddr_next;
      readLeft_reg <= readLeft_next;
      wrAddr_reg   <= wrAddr_next;
      wrLeft_reg   <= wrLeft_next;
    end
  end

  // ----------------------------------------
  // register port, calibration and control pulses
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regWrEn         <= 1'b0;
      regWrAddr       <= 4'h0;
      regWrData       <= 8'h00;
      loadRegPend_reg <= 1'b0;
      calStart        <= 1'b0;
      calKind         <= CAL_SYS_OFFSET;
      calCoef_reg     <= 24'h000000;
      filterClear     <= 1'b0;
      regReset        <= 1'b0;
    end else begin
      regWrEn         <= wrPulse;
      regWrAddr       <= wrAddr_reg;
      regWrData       <= wrByte;
      loadRegPend_reg <= loadRegReq;
      calStart        <= cmdCal;
      if (cmdCal) begin
        calKind <= cmdSysGain ? CAL_SYS_GAIN : (cmdIntOffset ? CAL_INT_OFFSET : CAL_SYS_OFFSET);
      end
      if (calDone && state_reg == ST_CAL_WAIT) begin
        calCoef_reg <= calResult;
      end
      filterClear <= cmdSync | cmdReset;
      regReset    <= cmdReset;
    end
  end

  assign regRdAddr = readAddr_reg;
  assign resetHold = holdActive;

  // ----------------------------------------
  // conversion and readout mode
  // ----------------------------------------
  logic sleepPending_reg;
  logic autoPending_reg;
  logic autoLoad_reg;
  logic [`RESULT_W-1:0] latestResult_reg;

  // sleep only gates conversions; no reference control leaves this block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      convEnable       <= `CONV_ENABLE_RESET;
      sleepPending_reg <= 1'b0;
    end else if (cmdResume || wakeHit) begin
      convEnable       <= 1'b1;
      sleepPending_reg <= 1'b0;
    end else if (cmdSleep) begin
      sleepPending_reg <= 1'b1;
    end else if (convDone && sleepPending_reg) begin
      convEnable       <= 1'b0;
      sleepPending_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      autoPending_reg <= `AUTO_LOAD_RESET;
      autoLoad_reg    <= `AUTO_LOAD_RESET;
    end else if (cmdReset) begin
      autoPending_reg <= `AUTO_LOAD_RESET;
      autoLoad_reg    <= `AUTO_LOAD_RESET;
    end else begin
      if (cmdAutoLoad) begin
        autoPending_reg <= 1'b1;
      end else if (cmdStopAuto) begin
        autoPending_reg <= 1'b0;
      end
      if (convDone) begin
        autoLoad_reg <= autoPending_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latestResult_reg <= 24'h000000;
    end else if (convDone) begin
      latestResult_reg <= convResult;
    end
  end

  // a pending mode change is what the ready event acts on
  wire autoLoadHit = convDone & autoPending_reg;
  wire loadResult  = autoLoadHit | cmdReadOnce;
  wire [`RESULT_W-1:0] resultSrc = convDone ? convResult : latestResult_reg;

  // ----------------------------------------
  // serial transmit
  // ----------------------------------------
  logic [`RESULT_W-1:0] outShift_reg;
  logic                 dataBit_reg;
  logic                 shown_reg;

  // a load mid-byte corrupts the byte; hosts must finish reading first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outShift_reg <= 24'h000000;
      dataBit_reg  <= 1'b0;
    end else if (loadRegPend_reg) begin
      outShift_reg <= {regRdData, 16'h0000};
    end else if (loadResult) begin
      outShift_reg <= resultSrc;
    end else if (sclkRise) begin
      dataBit_reg  <= outShift_reg[`RESULT_W-1];
      outShift_reg <= {outShift_reg[`RESULT_W-2:0], 1'b0};
    end
  end

  // new result wins over the clearing clock edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resultReadyN <= 1'b1;
      shown_reg    <= 1'b0;
    end else if (convDone) begin
      resultReadyN <= 1'b0;
      shown_reg    <= 1'b0;
    end else if (sclkRise) begin
      resultReadyN <= 1'b1;
      shown_reg    <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      doutPin <= 1'b0;
      doutOe  <= 1'b0;
    end else begin
      doutPin <= (readyOnOutputSelect & ~shown_reg) ? resultReadyN : dataBit_reg;
      doutOe  <= ~csN;
    end
  end
endmodule

`default_nettype wire

/* tb/adc_cmd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic csNPin,
  input wire logic doutOe,
  input wire logic resultReadyN,
  input wire logic convDone,
  input wire logic convEnable,
  input wire logic filterClear,
  input wire logic regReset,
  input wire logic resetHold,
  input wire logic regWrEn,
  input wire logic calStart
);
  // ----
  // port timing
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_clear_one_cycle: assert property (filterClear |=> !filterClear)
    else $error("clear too long");
  a_reset_clears: assert property (regReset |-> filterClear)
    else $error("reset without clear");
  a_reset_holds: assert property (regReset |-> ##[0:3] resetHold)
    else $error("no hold after reset");
  a_hold_blocks_work: assert property (resetHold |-> !calStart && !regWrEn)
    else $error("work during hold");
  a_ready_on_done: assert property (convDone |=> !resultReadyN)
    else $error("ready missed");
  a_ready_has_cause: assert property ($fell(resultReadyN) |-> $past(convDone))
    else $error("ready without result");
  a_sleep_at_done: assert property ($fell(convEnable) |-> $past(convDone))
    else $error("sleep mid conversion");
  a_cal_write_late: assert property (calStart |=> !calStart && !regWrEn)
    else $error("early coefficient write");
  a_oe_idle_off: assert property (csNPin [*5] |-> !doutOe)
    else $error("output on while deselected");
  c_cal: cover property (calStart);
  c_reset: cover property (regReset);
  c_sleep: cover property ($fell(convEnable));
endmodule
bind adc_serial_command_decoder adc_cmd_checker i_chk (.sys_clk(sys_clk), .rst(rst), .csNPin(csNPin),
  .doutOe(doutOe), .resultReadyN(resultReadyN), .convDone(convDone), .convEnable(convEnable),
  .filterClear(filterClear), .regReset(regReset), .resetHold(resetHold), .regWrEn(regWrEn), .calStart(calStart));
`default_nettype wire

/* tb/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic sys_clk,
  input  wire logic doutPin,
  output var logic  sclkPin,
  output var logic  csNPin,
  output var logic  dinPin
);
  // ----
  // host side of the link
  // ----
  initial begin
    sclkPin = 1'h0;
    csNPin  = 1'h1;
    dinPin  = 1'h1;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // raising select realigns a stray bit count
  task automatic frame(input logic sel);
    pause(4);
    csNPin <= !sel;
    dinPin <= !dinPin; // released line never keeps its last bit
    pause(4);
  endtask
  // whole bytes only, msb first; sclk rests low outside frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclkPin <= 1'h1;
      dinPin  <= tx[i];
      pause(6);
      rx[i] = doutPin;
      sclkPin <= 1'h0;
      pause(6);
    end
  endtask
endmodule
`default_nettype wire

/* tb/adc_serial_command_decoder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_decoder_tb_top;
  import adc_cmd_pkg::*;
  localparam int unsigned HOLD = 60;
  logic         sys_clk, rst, sclkPin, csNPin, dinPin, doutPin, doutOe, resultReadyN, convDone, convEnable;
  logic         filterClear, regReset, resetHold, readyOnOutputSelect, regWrEn, calStart, calDone, cmdFifoReady;
  logic [23:0]  convResult, calResult, val, got;
  logic [7:0]   regWrData, rx, regRdData, regs [16];
  logic [3:0]   regRdAddr, regWrAddr;
  logic [11:0]  wrQ [$];
  cal_kind_type calKind;
  int           fail_count, checks_done, cycles, nClr, nRst, nCal, lastKind, n, m;
  // ----
  // design, host and register file
  // ----
  assign regRdData = regs[regRdAddr];
  adc_serial_command_decoder #(.RESET_HOLD_CYCLES(HOLD), .POWERUP_CYCLES(HOLD)) i_dut (.sys_clk(sys_clk),
    .rst(rst), .sclkPin(sclkPin), .csNPin(csNPin), .dinPin(dinPin), .doutPin(doutPin), .doutOe(doutOe),
    .resultReadyN(resultReadyN), .convDone(convDone), .convResult(convResult), .convEnable(convEnable),
    .filterClear(filterClear), .regReset(regReset), .resetHold(resetHold),
    .readyOnOutputSelect(readyOnOutputSelect), .regRdAddr(regRdAddr), .regRdData(regRdData), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .calStart(calStart), .calKind(calKind), .calDone(calDone),
    .calResult(calResult), .cmdFifoReady(cmdFifoReady));
  spi_host_model i_host (.sys_clk(sys_clk), .doutPin(doutPin), .sclkPin(sclkPin), .csNPin(csNPin), .dinPin(dinPin));
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic conv(input logic [23:0] r);
    convResult <= r;
    convDone   <= 1'h1;
    @(posedge sys_clk);
    convDone   <= 1'h0;
    i_host.pause(4);
  endtask
  task automatic cmd(input logic [7:0] b);
    i_host.frame(1'h1);
    i_host.xfer(b, rx);
    i_host.frame(1'h0);
    i_host.pause(24);
  endtask
  task automatic get_result(input logic [7:0] last);
    i_host.xfer(8'hFF, got[23:16]);
    i_host.xfer(8'hFF, got[15:8]);
    i_host.xfer(last, got[7:0]);
  endtask
  // hold is counted from wherever it is first seen, so it may read short
  task automatic hold_len;
    n = 0;
    for (int w = 0; w < 100 && resetHold !== 1'h1; w++) @(negedge sys_clk);
    while (resetHold === 1'h1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 40000) begin
      fail_count++;
      complete_run();
    end
    nClr += filterClear;
    nRst += regReset;
    if (calStart === 1'h1) begin
      nCal++;
      lastKind = calKind;
    end
    if (regWrEn === 1'h1) check({regWrAddr, regWrData}, wrQ.size() ? wrQ.pop_front() : 12'hFFF);
  end
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(32'hD77490D4));
    rst = 1'h1;
    convDone = 1'h0;
    convResult = 24'h0;
    calDone = 1'h0;
    calResult = 24'h0;
    readyOnOutputSelect = 1'h0;
    foreach (regs[i]) regs[i] = 8'($urandom);
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    hold_len();
    check(n >= HOLD, 1'h1);
    readyOnOutputSelect <= 1'h1;
    i_host.frame(1'h1);
    check({doutPin, resultReadyN}, 2'h3);
    val = 24'($urandom);
    conv(val);
    check({doutPin, resultReadyN}, 2'h0);
    get_result(8'h12);
    check(got, val);
    i_host.pause(24);
    get_result(8'hFF);
    check(got, val);
    i_host.frame(1'h0);
    readyOnOutputSelect <= 1'h0;
    i_host.frame(1'h1);
    i_host.xfer(8'h4E, rx);
    i_host.xfer(8'h02, rx);
    for (int i = 0; i < 3; i++) begin
      val[7:0] = 8'($urandom);
      regs[4'(14 + i)] = val[7:0];
      wrQ.push_back({4'(14 + i), val[7:0]});
      i_host.xfer(val[7:0], rx);
    end
    i_host.frame(1'h0);
    i_host.pause(24);
    check(wrQ.size(), 0);
    m = nRst;
    i_host.frame(1'h1);
    i_host.xfer(8'h2F, rx);
    i_host.xfer(8'h01, rx);
    i_host.pause(24);
    i_host.xfer(8'h06, rx);
    check(rx, regs[15]);
    i_host.xfer(8'hFF, rx);
    check({rx, nRst[3:0]}, {regs[0], 4'(m)});
    i_host.frame(1'h0);
    cmd(8'h16);
    val = 24'($urandom);
    conv(val);
    i_host.frame(1'h1);
    i_host.xfer(8'h12, rx);
    i_host.pause(24);
    get_result(8'hFF);
    check(got, val);
    i_host.frame(1'h0);
    cmd(8'h14);
    val = 24'($urandom);
    conv(val);
    i_host.frame(1'h1);
    get_result(8'hFF);
    check(got, val);
    i_host.frame(1'h0);
    cmd(8'h02);
    check(convEnable, 1'h1);
    conv(24'($urandom));
    check(convEnable, 1'h0);
    cmd(8'h00);
    check(convEnable, 1'h1);
    m = nClr;
    cmd(8'h04);
    cmd(8'h30);
    cmd(8'h5A);
    check(nClr, m + 1);
    for (int k = 0; k < 3; k++) begin
      cmd(8'h60 + 8'(k));
      i_host.frame(1'h1);
      for (int b = 0; b < 17 && k == 0; b++) i_host.xfer(8'hFF, rx);
      i_host.frame(1'h0);
      check({nCal, lastKind, cmdFifoReady}, {k + 1, k, k != 0});
      val = 24'($urandom);
      for (int j = 0; j < 3; j++) wrQ.push_back({4'((k == 1 ? 7 : 4) + j), val[8 * j +: 8]});
      calResult <= val;
      calDone   <= 1'h1;
      @(posedge sys_clk);
      calDone   <= 1'h0;
      i_host.pause(100);
      check({wrQ.size(), cmdFifoReady}, {32'h0, 1'h1});
    end
    cmd(8'h16);
    conv(24'($urandom));
    m = nRst;
    i_host.frame(1'h1);
    i_host.xfer(8'h06, rx);
    i_host.frame(1'h0);
    hold_len();
    check({n > HOLD / 2, nRst}, {1'h1, m + 1});
    val = 24'($urandom);
    conv(val);
    i_host.frame(1'h1);
    get_result(8'hFF);
    check(got, val);
    i_host.frame(1'h0);
    complete_run();
  end
endmodule
`default_nettype wire
